/* File: rtl/pic_control_groups.sv */
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/100ps
// Summary of operation
// - Wide switch and option give 136, else 132.
// - Buffer-full auto print follows the wide switch.
// - Delete switch on: 7F printable, alternate table no busy.
// - Delete switch off: 7F not printed, busy set.
// - Truncate switch stops skips at next top of form.
// - Port decoder enables one of seven input sources.
// - Group strobe selects group; lines 10-13 carry code.
// - Latch groups: lines 10-12 pick bit, 13 is level.
// - Group 0 codes 0000/1000 assert/negate paper empty.
// - Group 0 codes 0001/1001 gate the busy-set path.
// - Group 2 decodes with line 13: toggle, busy clear.
// - Group 3 strobes active low; line 13 low ignored.
// - Group 3 line-13-high codes pulse eight strobes in order.
// - Group 5 0001 alarm on offline; 1001 reverse.
// - Group 5 0011/1011 negate/assert host acknowledge.
// - Group 5 0100/1100 assert/negate host select.
// - Group 5 0101/1101 negate/assert host fault.
// - Group 6 0011 sets, 1011 resets busy-and-hold.
module pic_control_groups #(
  parameter int NARROW_COLS_P = pic_pkg::NARROW_COLS,
  parameter int WIDE_COLS_P = pic_pkg::WIDE_COLS
) (
  input wire logic core_clk_in, // System clock, 100 MHz.
  input wire logic rst_in, // Synchronous reset, active high.
  input wire logic group0_enable_n_in, // Group 0 enable, active low.
  input wire logic group2_enable_n_in, // Group 2 enable, active low.
  input wire logic group3_enable_n_in, // Group 3 enable, active low.
  input wire logic group5_enable_n_in, // Group 5 enable, active low.
  input wire logic group6_enable_n_in, // Group 6 enable, active low.
  input wire logic [3:0] proc_addr_line_in, // Address lines 13..10 (bit 0 is line 10).
  input wire logic [2:0] port_select_in, // Input port code; 7 selects nothing.
  input wire logic port_select_en_in, // Input port read enable.
  input wire logic [pic_pkg::PORT_N*8-1:0] port_src_in, // Seven source bytes, port 0 lowest.
  output logic [7:0] proc_input_bus_out, // Selected source byte.
  output logic [pic_pkg::PORT_N-1:0] port_enable_n_out, // One-hot source enables, active low.
  input wire logic wide_column_switch_in, // Wide-column switch pin.
  input wire logic printable_delete_switch_in, // Printable-delete switch pin.
  input wire logic step_truncate_switch_in, // Step-count truncation switch pin.
  input wire logic buffer_full_print_switch_in, // Buffer-full line feed switch pin.
  input wire logic [7:0] user_data_in, // Latched host data byte.
  input wire logic data_strobe_in, // One-cycle pulse: new host byte.
  input wire logic busy_code_in, // Decode table asks busy for the byte.
  input wire logic [7:0] buffer_count_in, // Characters held in line buffer.
  input wire logic [7:0] skip_lines_in, // Requested line skip.
  input wire logic [7:0] lines_to_tof_in, // Lines left to next top of form.
  output logic [7:0] line_columns_out, // Printed columns per line.
  output logic auto_print_out, // Print now on full buffer.
  output logic delete_printable_out, // 7F is printed as a character.
  output logic [7:0] step_count_out, // Skip length after truncation.
  output logic paper_empty_out, // Host paper-empty line, active high.
  output logic ack_n_out, // Host acknowledge, active low.
  output logic select_out, // Host select line, active high.
  output logic fault_n_out, // Host fault, active low.
  output logic busy_out, // Host busy line, active high.
  output logic alarm_lamp_n_out, // Alarm lamp drive, active low.
  output logic alarm_lamp_reset_out, // Alarm lamp reset, high when online with the alarm lamp off.
  output logic online_out, // Online state.
  output logic [7:0] group6_latch_out, // Group 6 held outputs.
  output logic online_toggle_n_out, // Group 2 online toggle strobe.
  output logic ribbon_sensor_clear_n_out, // Group 3 strobe 1000.
  output logic forms_addr_load_n_out, // Group 3 strobe 1001.
  output logic paper_motion_flag_clear_n_out, // Group 3 strobe 1010.
  output logic master_clear_set_n_out, // Group 3 strobe 1011.
  output logic ribbon_sensor_load_n_out, // Group 3 strobe 1100.
  output logic display_reg_load_n_out, // Group 3 strobe 1101.
  output logic online_reset_n_out, // Group 3 strobe 1110.
  output logic strobe_latch_clear_n_out, // Group 3 strobe 1111.
  input wire logic [pic_pkg::ADDR_W-1:0] reg_addr_in, // Register address.
  input wire logic [pic_pkg::DATA_W-1:0] reg_wdata_in, // Register write data.
  input wire logic reg_write_in, // Write strobe.
  input wire logic reg_read_in, // Read strobe.
  output logic [pic_pkg::DATA_W-1:0] reg_rdata_out, // Read data, cycle after strobe.
  output logic irq_out // Level interrupt.
);
  import pic_pkg::*;

  // Column counts travel on eight-bit outputs, so anything above 255 is refused.
  if (NARROW_COLS_P < 1 || WIDE_COLS_P <= NARROW_COLS_P || WIDE_COLS_P > 255) begin : g_bad_cols
    $error("Column counts must satisfy 0 < narrow < wide < 256.");
  end

  localparam logic [7:0] NARROW_C = 8'(NARROW_COLS_P);
  localparam logic [7:0] WIDE_C = 8'(WIDE_COLS_P);

  // Switch pins are asynchronous; two flops before use.
  logic [3:0] sw_meta;
  logic [3:0] sw_sync;
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sw_meta <= 4'h0;
      sw_sync <= 4'h0;
    end else begin
      sw_meta <= {buffer_full_print_switch_in, step_truncate_switch_in,
                  printable_delete_switch_in, wide_column_switch_in};
      sw_sync <= sw_meta;
    end
  end
  logic wide_sw;
  logic pdel_sw;
  logic trunc_sw;
  logic bfull_sw;
  assign wide_sw = sw_sync[0];
  assign pdel_sw = sw_sync[1];
  assign trunc_sw = sw_sync[2];
  assign bfull_sw = sw_sync[3];

  // One access per falling edge of a group enable.
  logic [4:0] en_n;
  logic [4:0] en_prev_n;
  logic [4:0] access;
  assign en_n = {group6_enable_n_in, group5_enable_n_in, group3_enable_n_in,
                 group2_enable_n_in, group0_enable_n_in};
  assign access = en_prev_n & ~en_n;
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      en_prev_n <= 5'h1F;
    end else begin
      en_prev_n <= en_n;
    end
  end

  logic [2:0] sel;
  logic level;
  assign sel = proc_addr_line_in[2:0];
  assign level = proc_addr_line_in[3];

  // Addressable latches: one bit written, the rest hold.
  logic [7:0] g0;
  logic [7:0] g5;
  logic [7:0] g6;
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      g0 <= G0_RST;
    end else if (access[0]) begin
      g0[sel] <= level;
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      g5 <= G5_RST;
    end else if (access[3]) begin
      g5[sel] <= level;
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      g6 <= G6_RST;
    end else if (access[4]) begin
      g6[sel] <= level;
    end
  end

  assign paper_empty_out = ~g0[G0_PAPER_EMPTY_BIT];
  assign ack_n_out = ~g5[G5_ACK_BIT];
  assign select_out = ~g5[G5_SELECT_BIT];
  assign fault_n_out = ~g5[G5_FAULT_BIT];
  assign alarm_lamp_n_out = g5[G5_ALARM_BIT];
  assign group6_latch_out = g6;

  // Decoder strobes, registered so each lasts exactly one cycle.
  logic g2_hit;
  logic g3_hit;
  logic [7:0] g3_strobe_n;
  logic online_toggle_n;
  assign g2_hit = access[1] & level;
  assign g3_hit = access[2] & level;
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      online_toggle_n <= 1'b1;
    end else begin
      online_toggle_n <= ~(g2_hit && sel == G2_TOGGLE_CODE);
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_g3
      always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
          g3_strobe_n[gi] <= 1'b1;
        end else begin
          g3_strobe_n[gi] <= ~(g3_hit && sel == 3'(gi));
        end
      end
    end
  endgenerate
  assign online_toggle_n_out = online_toggle_n;
  assign ribbon_sensor_clear_n_out = g3_strobe_n[0];
  assign forms_addr_load_n_out = g3_strobe_n[1];
  assign paper_motion_flag_clear_n_out = g3_strobe_n[2];
  assign master_clear_set_n_out = g3_strobe_n[3];
  assign ribbon_sensor_load_n_out = g3_strobe_n[4];
  assign display_reg_load_n_out = g3_strobe_n[5];
  assign online_reset_n_out = g3_strobe_n[6];
  assign strobe_latch_clear_n_out = g3_strobe_n[7];

  // Online flip-flop: toggled by group 2, reset by group 3, forced by group 5.
  logic online;
  logic online_chg;
  logic g5_alarm_hit;
  assign g5_alarm_hit = access[3] && sel == 3'(G5_ALARM_BIT);
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      online <= 1'b0;
    end else if (g5_alarm_hit) begin
      online <= level;
    end else if (g3_hit && sel == G3_ONLINE_RESET_CODE) begin
      online <= 1'b0;
    end else if (g2_hit && sel == G2_TOGGLE_CODE) begin
      online <= ~online;
    end
  end
  assign online_chg = g5_alarm_hit || (g3_hit && sel == G3_ONLINE_RESET_CODE)
                      || (g2_hit && sel == G2_TOGGLE_CODE);
  assign online_out = online;
  assign alarm_lamp_reset_out = online & g5[G5_ALARM_BIT];

  // Busy latch fed by the decode table, gated by the group 0 enable bit.
  logic [7:0] cfg;
  logic is_delete;
  logic busy_req;
  logic busy_set;
  logic busy;
  assign is_delete = user_data_in == DELETE_CODE;
  always_comb begin
    if (is_delete) begin
      busy_req = ~(pdel_sw & cfg[CFG_ALT_TABLE_BIT]);
    end else begin
      busy_req = busy_code_in;
    end
  end
  assign busy_set = data_strobe_in & busy_req & g0[G0_BUSY_SET_EN_BIT];
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      busy <= 1'b0;
    end else if (busy_set) begin
      busy <= 1'b1;
    end else if (g2_hit && sel == G2_BUSY_CLR_CODE) begin
      busy <= 1'b0;
    end
  end
  assign busy_out = busy | ~g6[G6_BUSY_HOLD_BIT];
  assign delete_printable_out = pdel_sw;

  // Line length and buffer-full printing.
  logic [7:0] col_limit;
  logic [7:0] next_step;
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      col_limit <= NARROW_C;
      line_columns_out <= NARROW_C;
    end else begin
      // Without the wide option the last four of 136 are lost.
      col_limit <= wide_sw ? WIDE_C : NARROW_C;
      line_columns_out <= (wide_sw && cfg[CFG_WIDE_OPT_BIT]) ? WIDE_C : NARROW_C;
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      auto_print_out <= 1'b0;
    end else begin
      auto_print_out <= ~bfull_sw && buffer_count_in >= col_limit;
    end
  end
  always_comb begin
    next_step = skip_lines_in;
    if (trunc_sw && skip_lines_in > lines_to_tof_in) begin
      next_step = lines_to_tof_in;
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      step_count_out <= 8'h00;
    end else begin
      step_count_out <= next_step;
    end
  end

  // Input port decoder; code 7 leaves the bus idle.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      proc_input_bus_out <= 8'h00;
    end else if (port_select_en_in && port_select_in != 3'h7) begin
      proc_input_bus_out <= port_src_in[port_select_in*8 +: 8];
    end else begin
      proc_input_bus_out <= 8'h00;
    end
  end
  generate
    for (gi = 0; gi < PORT_N; gi++) begin : g_port
      assign port_enable_n_out[gi] = ~(port_select_en_in && port_select_in == 3'(gi));
    end
  endgenerate

  // Register file and interrupts.
  logic [7:0] irq_mask;
  logic [IRQ_N-1:0] irq_stat;
  logic [IRQ_N-1:0] irq_event;
  logic stat_read;
  assign irq_event[IRQ_BUSY_SET_BIT] = busy_set & ~busy;
  assign irq_event[IRQ_ONLINE_CHG_BIT] = online_chg;
  assign irq_event[IRQ_MCLR_BIT] = g3_hit && sel == G3_MCLR_CODE;
  assign irq_event[IRQ_DELETE_BIT] = data_strobe_in & is_delete;
  assign stat_read = reg_read_in && reg_addr_in == IRQ_STAT_ADDR;
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cfg <= CFG_RST;
      irq_mask <= IRQ_MASK_RST;
    end else if (reg_write_in) begin
      if (reg_addr_in == CFG_ADDR) begin
        cfg <= reg_wdata_in;
      end
      if (reg_addr_in == IRQ_MASK_ADDR) begin
        irq_mask <= reg_wdata_in;
      end
    end
  end
  // A new event in the clearing cycle stays set.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (stat_read ? '0 : irq_stat) | irq_event;
    end
  end
  assign irq_out = |(irq_stat & irq_mask[IRQ_N-1:0]);
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_read_in) begin
      unique case (reg_addr_in)
        CFG_ADDR: reg_rdata_out <= cfg;
        STATE_ADDR: reg_rdata_out <= {2'h0, ~g6[G6_BUSY_HOLD_BIT], busy, select_out,
                                      paper_empty_out, ~g5[G5_ALARM_BIT], online};
        IRQ_STAT_ADDR: reg_rdata_out <= {{(8-IRQ_N){1'b0}}, irq_stat};
        IRQ_MASK_ADDR: reg_rdata_out <= irq_mask;
      endcase
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end
endmodule

/* File: rtl/pic_pkg.sv */
package pic_pkg;
  // Register bus layout.
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;
  localparam logic [1:0] CFG_ADDR = 2'h0;
  localparam logic [1:0] STATE_ADDR = 2'h1;
  localparam logic [1:0] IRQ_STAT_ADDR = 2'h2;
  localparam logic [1:0] IRQ_MASK_ADDR = 2'h3;
  // Configuration register fields.
  localparam int CFG_WIDE_OPT_BIT = 0;
  localparam int CFG_ALT_TABLE_BIT = 1;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] IRQ_MASK_RST = 8'h00;
  // Interrupt event bits.
  localparam int IRQ_BUSY_SET_BIT = 0;
  localparam int IRQ_ONLINE_CHG_BIT = 1;
  localparam int IRQ_MCLR_BIT = 2;
  localparam int IRQ_DELETE_BIT = 3;
  localparam int IRQ_N = 4;
  // Latch bit positions.
  localparam int G0_PAPER_EMPTY_BIT = 0;
  localparam int G0_BUSY_SET_EN_BIT = 1;
  localparam int G5_ALARM_BIT = 1;
  localparam int G5_ACK_BIT = 3;
  localparam int G5_SELECT_BIT = 4;
  localparam int G5_FAULT_BIT = 5;
  localparam int G6_BUSY_HOLD_BIT = 3;
  // Latch reset values: every held output at its inactive level.
  localparam logic [7:0] G0_RST = 8'h01;
  localparam logic [7:0] G5_RST = 8'h12;
  localparam logic [7:0] G6_RST = 8'h08;
  // Decoder codes on lines 12..10.
  localparam logic [2:0] G2_TOGGLE_CODE = 3'h0;
  localparam logic [2:0] G2_BUSY_CLR_CODE = 3'h1;
  localparam logic [2:0] G3_ONLINE_RESET_CODE = 3'h6;
  localparam logic [2:0] G3_MCLR_CODE = 3'h3;
  localparam logic [7:0] DELETE_CODE = 8'h7F;
  localparam int NARROW_COLS = 132;
  localparam int WIDE_COLS = 136;
  localparam int PORT_N = 7;
endpackage

/* File: testbench/pic_control_groups_props.sv */
`timescale 1ns/100ps
module pic_control_groups_props (
  input wire logic core_clk_in, // Clock.
  input wire logic rst_in, // Reset.
  input wire logic group0_enable_n_in, // Enable.
  input wire logic group2_enable_n_in, // Enable.
  input wire logic group3_enable_n_in, // Enable.
  input wire logic group5_enable_n_in, // Enable.
  input wire logic group6_enable_n_in, // Enable.
  input wire logic [3:0] proc_addr_line_in, // Code.
  input wire logic paper_empty_out, // Host line.
  input wire logic ack_n_out, // Host line.
  input wire logic select_out, // Host line.
  input wire logic fault_n_out, // Host line.
  input wire logic busy_out, // Host line.
  input wire logic alarm_lamp_n_out, // Lamp.
  input wire logic online_out, // Online.
  input wire logic online_toggle_n_out, // Strobe.
  input wire logic master_clear_set_n_out // Strobe.
);
  logic [4:0] was_n;
  wire logic [4:0] en_n = {group6_enable_n_in, group5_enable_n_in, group3_enable_n_in,
    group2_enable_n_in, group0_enable_n_in};
  // An access counts only on the first low cycle, as the design takes it.
  wire logic [4:0] acc = was_n & ~en_n;
  wire logic [3:0] a = proc_addr_line_in;
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      was_n <= 5'h1F;
    end else begin
      was_n <= en_n;
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  pe_set_a: assert property (acc[0] && a == 4'h0 |=> paper_empty_out)
    else $error("paper empty not asserted");
  ack_set_a: assert property (acc[3] && a == 4'hB |=> !ack_n_out)
    else $error("acknowledge not asserted");
  select_keep_a: assert property (acc[3] && a == 4'h4 |=>
    select_out && $stable(fault_n_out) && $stable(ack_n_out))
    else $error("select write wrong");
  fault_set_a: assert property (acc[3] && a == 4'hD |=> !fault_n_out)
    else $error("fault not asserted");
  alarm_on_a: assert property (acc[3] && a == 4'h1 |=> !alarm_lamp_n_out && !online_out)
    else $error("alarm write wrong");
  hold_busy_a: assert property (acc[4] && a == 4'h3 |=> busy_out)
    else $error("busy hold not set");
  toggle_pulse_a: assert property (acc[1] && a == 4'h8 |=>
    !online_toggle_n_out ##1 online_toggle_n_out)
    else $error("toggle pulse wrong");
  mclr_pulse_a: assert property (acc[2] && a == 4'hB |=>
    !master_clear_set_n_out ##1 master_clear_set_n_out)
    else $error("master clear pulse wrong");
  low_ignored_a: assert property ((acc[1] || acc[2]) && !a[3] |=>
    online_toggle_n_out && master_clear_set_n_out)
    else $error("line 13 low gave a strobe");
  reset_idle_a: assert property ($fell(rst_in) |-> !paper_empty_out && ack_n_out &&
    !select_out && fault_n_out && !busy_out)
    else $error("reset levels wrong");
endmodule
bind pic_control_groups pic_control_groups_props u_pic_control_groups_props (.*);

/* File: testbench/pic_proc_model.sv */
`timescale 1ns/100ps
module pic_proc_model (
  input wire logic clk_in, // Clock.
  input wire logic rst_in, // Reset, active high.
  input wire logic go_in, // Start one access.
  input wire logic [2:0] grp_in, // Slot 0..4 for groups 0,2,3,5,6.
  input wire logic [3:0] code_in, // Code for lines 13..10.
  output logic [4:0] en_n_out, // Group enables, active low.
  output logic [3:0] addr_out, // Lines 13..10.
  output logic busy_out // Access under way.
);
  logic [1:0] ph;
  assign busy_out = (ph != 2'h0);
  // The bus floats after the enable rises, so it shows the inverse code.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ph <= 2'h0;
      en_n_out <= 5'h1F;
      addr_out <= 4'h0;
    end else if (ph == 2'h0 && go_in) begin
      ph <= 2'h1;
      en_n_out[grp_in] <= 1'b0;
      addr_out <= code_in;
    end else if (ph == 2'h1) begin
      ph <= 2'h2;
      en_n_out <= 5'h1F;
      addr_out <= ~addr_out;
    end else begin
      ph <= 2'h0;
    end
  end
endmodule

/* File: testbench/test_pic_control_groups.sv */
`timescale 1ns/100ps
module test_pic_control_groups;
  import pic_pkg::*;
  logic core_clk_in, rst_in, port_select_en_in, go, mbusy, clr, data_strobe_in, busy_code_in;
  logic group0_enable_n_in, group2_enable_n_in, group3_enable_n_in;
  logic group5_enable_n_in, group6_enable_n_in, reg_write_in, reg_read_in, irq_out;
  logic [3:0] proc_addr_line_in, code;
  logic [2:0] port_select_in, slot;
  logic [4:0] pen;
  logic [55:0] port_src_in;
  logic [7:0] proc_input_bus_out, user_data_in, buffer_count_in, skip_lines_in;
  logic [7:0] lines_to_tof_in, line_columns_out, step_count_out, group6_latch_out;
  logic [7:0] reg_wdata_in, reg_rdata_out;
  logic [6:0] port_enable_n_out;
  logic [1:0] reg_addr_in;
  logic wide_column_switch_in, printable_delete_switch_in, step_truncate_switch_in;
  logic buffer_full_print_switch_in, auto_print_out, delete_printable_out;
  logic paper_empty_out, ack_n_out, select_out, fault_n_out, busy_out, alarm_lamp_n_out;
  logic alarm_lamp_reset_out, online_out, online_toggle_n_out, ribbon_sensor_clear_n_out;
  logic forms_addr_load_n_out, paper_motion_flag_clear_n_out, master_clear_set_n_out;
  logic ribbon_sensor_load_n_out, display_reg_load_n_out, online_reset_n_out;
  logic strobe_latch_clear_n_out;
  logic [8:0] strb, seen;
  int lows, error_cnt, checks_done;
  assign {group6_enable_n_in, group5_enable_n_in, group3_enable_n_in, group2_enable_n_in,
    group0_enable_n_in} = pen;
  assign strb = {online_toggle_n_out, strobe_latch_clear_n_out, online_reset_n_out,
    display_reg_load_n_out, ribbon_sensor_load_n_out, master_clear_set_n_out,
    paper_motion_flag_clear_n_out, forms_addr_load_n_out, ribbon_sensor_clear_n_out};
  pic_control_groups u_pic_control_groups (.*);
  pic_proc_model u_pic_proc_model (.clk_in(core_clk_in), .rst_in(rst_in), .go_in(go),
    .grp_in(slot), .code_in(code), .en_n_out(pen), .addr_out(proc_addr_line_in),
    .busy_out(mbusy));
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  // Strobes are one cycle wide, so they are caught by edge sampling, not by polling.
  always @(posedge core_clk_in) begin
    if (clr) begin
      seen <= 9'h000;
      lows <= 0;
    end else begin
      seen <= seen | ~strb;
      lows <= lows + int'(strb != 9'h1FF);
    end
  end
  task automatic chk(input logic [8:0] s, input logic [8:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic wrap_up;
    $display("Checks made %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  task automatic grp(input logic [2:0] s, input logic [3:0] c);
    int n;
    @(posedge core_clk_in);
    go <= 1'b1;
    slot <= s;
    code <= c;
    clr <= 1'b1;
    @(posedge core_clk_in);
    go <= 1'b0;
    clr <= 1'b0;
    n = 0;
    #1;
    while (mbusy && n < 20) begin
      tk(1);
      n++;
    end
    if (n == 20) begin
      error_cnt++;
      wrap_up;
    end
    tk(2);
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    reg_write_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge core_clk_in);
    reg_write_in <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge core_clk_in);
    reg_read_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge core_clk_in);
    reg_read_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask
  task automatic sw(input logic [3:0] v);
    @(posedge core_clk_in);
    {buffer_full_print_switch_in, step_truncate_switch_in, printable_delete_switch_in,
      wide_column_switch_in} <= v;
    tk(4);
  endtask
  task automatic dstb(input logic [7:0] d, input logic b);
    @(posedge core_clk_in);
    data_strobe_in <= 1'b1;
    user_data_in <= d;
    busy_code_in <= b;
    @(posedge core_clk_in);
    data_strobe_in <= 1'b0;
    tk(2);
  endtask
  task automatic t_reset;
    logic [7:0] d;
    chk({paper_empty_out, ack_n_out, select_out, fault_n_out, busy_out, alarm_lamp_n_out,
      online_out}, 9'h02A);
    chk(strb, 9'h1FF);
    chk(group6_latch_out, G6_RST);
    rd(IRQ_MASK_ADDR, d);
    chk(d, IRQ_MASK_RST);
    $display("t_reset done");
  endtask
  task automatic t_g5;
    logic [3:0] cd [8] = '{4'h1, 4'h9, 4'hB, 4'h3, 4'h4, 4'hC, 4'hD, 4'h5};
    logic [5:0] ex [8] = '{6'h05, 6'h3D, 6'h39, 6'h3D, 6'h3F, 6'h3D, 6'h3C, 6'h3D};
    for (int i = 0; i < 8; i++) begin
      grp(3'h3, cd[i]);
      chk({alarm_lamp_n_out, online_out, alarm_lamp_reset_out, ack_n_out, select_out,
        fault_n_out}, ex[i]);
    end
    $display("t_g5 done");
  endtask
  task automatic t_strb;
    logic [7:0] d;
    for (int i = 0; i < 16; i++) begin
      grp(3'h2, i[3:0]);
      chk(seen, i[3] ? 9'h001 << i[2:0] : 9'h000);
      chk(lows[8:0], {8'h00, i[3]});
    end
    grp(3'h1, 4'h0);
    chk(seen, 9'h000);
    grp(3'h1, 4'h8);
    chk(seen, 9'h100);
    chk(online_out, 1'b1);
    rd(IRQ_STAT_ADDR, d);
    chk(d, 8'h06);
    rd(IRQ_STAT_ADDR, d);
    chk(d, 8'h00);
    $display("t_strb done");
  endtask
  task automatic t_g6;
    logic [3:0] cd [4] = '{4'h3, 4'hF, 4'hB, 4'h7};
    logic [7:0] ex [4] = '{8'h00, 8'h80, 8'h88, 8'h08};
    for (int i = 0; i < 4; i++) begin
      grp(3'h4, cd[i]);
      chk({busy_out, group6_latch_out}, {i == 0 || i == 1, ex[i]});
    end
    $display("t_g6 done");
  endtask
  task automatic t_busy;
    logic [7:0] d;
    grp(3'h0, 4'h0);
    chk(paper_empty_out, 1'b1);
    grp(3'h0, 4'h8);
    chk(paper_empty_out, 1'b0);
    dstb(8'h41, 1'b1);
    chk(busy_out, 1'b0);
    grp(3'h0, 4'h9);
    dstb(8'h41, 1'b1);
    chk({busy_out, irq_out}, 9'h002);
    wr(IRQ_MASK_ADDR, 8'h09);
    tk(1);
    chk(irq_out, 1'b1);
    rd(IRQ_STAT_ADDR, d);
    chk({d, irq_out}, 9'h002);
    grp(3'h1, 4'h9);
    chk(busy_out, 1'b0);
    wr(CFG_ADDR, 8'h02);
    sw(4'h2);
    dstb(DELETE_CODE, 1'b0);
    chk(busy_out, 1'b0);
    sw(4'h0);
    dstb(DELETE_CODE, 1'b0);
    chk(busy_out, 1'b1);
    rd(STATE_ADDR, d);
    chk(d, 8'h11);
    rd(CFG_ADDR, d);
    chk(d, 8'h02);
    $display("t_busy done");
  endtask
  task automatic t_cfg;
    logic [3:0] sv [4] = '{4'h1, 4'h4, 4'hC, 4'h2};
    logic [7:0] ec [4] = '{8'd136, 8'd132, 8'd132, 8'd132};
    logic [7:0] es [4] = '{8'd10, 8'd4, 8'd4, 8'd10};
    logic [1:0] ef [4] = '{2'h0, 2'h2, 2'h0, 2'h3};
    wr(CFG_ADDR, 8'h01);
    for (int i = 0; i < 4; i++) begin
      sw(sv[i]);
      chk(line_columns_out, ec[i]);
      chk(step_count_out, es[i]);
      chk({auto_print_out, delete_printable_out}, ef[i]);
    end
    // Wide switch on without the option fitted still prints the narrow line.
    wr(CFG_ADDR, 8'h00);
    sw(4'h1);
    chk(line_columns_out, 8'd132);
    chk(auto_print_out, 1'b0);
    $display("t_cfg done");
  endtask
  task automatic t_ports;
    logic [7:0] by;
    for (int k = 0; k < 8; k++) begin
      @(posedge core_clk_in);
      port_select_in <= k[2:0];
      port_select_en_in <= 1'b1;
      tk(2);
      by = (k < 7) ? {k[3:0] + 4'h1, k[3:0]} : 8'h00;
      chk(proc_input_bus_out, by);
      chk(port_enable_n_out, 7'(~(7'h01 << k)));
    end
    $display("t_ports done");
  endtask
  initial begin
    {rst_in, clr} = 2'h3;
    {go, slot, code, port_select_en_in, port_select_in, data_strobe_in, busy_code_in} = '0;
    {reg_write_in, reg_read_in, reg_addr_in, reg_wdata_in, user_data_in} = '0;
    {wide_column_switch_in, printable_delete_switch_in, step_truncate_switch_in} = '0;
    buffer_full_print_switch_in = 1'b0;
    port_src_in = 56'h76_65_54_43_32_21_10;
    buffer_count_in = 8'd132;
    skip_lines_in = 8'd10;
    lines_to_tof_in = 8'd4;
    repeat (12) @(posedge core_clk_in);
    rst_in <= 1'b0;
    tk(1);
    t_reset;
    t_g5;
    t_strb;
    t_g6;
    t_busy;
    t_cfg;
    t_ports;
    wrap_up;
  end
endmodule
